// ---- verilog/cls_pkg.sv ----
// Package of register offsets, field positions and constants for the channel 0 loop status bank.
`default_nettype none
package cls_pkg;
    // Printed register indices; some are not multiples of four, so byte address is four times the index.
    localparam logic [11:0] IDX_UPDATE        = 12'h000F;
    localparam logic [11:0] IDX_LOCK_STATUS   = 12'h0D20;
    localparam logic [11:0] IDX_LOOP_STATE    = 12'h0D21;
    localparam logic [11:0] IDX_LIMIT_STATUS  = 12'h0D22;
    localparam logic [11:0] IDX_HISTORY_B0    = 12'h0D23;
    localparam logic [11:0] IDX_HISTORY_B1    = 12'h0D24;
    localparam logic [11:0] IDX_HISTORY_B2    = 12'h0D25;
    localparam logic [11:0] IDX_HISTORY_B3    = 12'h0D26;
    localparam logic [11:0] IDX_IRQ_STATUS    = 12'h0F00;
    localparam logic [11:0] IDX_IRQ_MASK      = 12'h0F01;
    localparam int          ADDR_SHIFT        = 2;
    // Value written to the update register to request a transfer.
    localparam logic [7:0]  UPDATE_STROBE_VAL = 8'h01;
    // Lock status fields.
    localparam int          LK_CAL            = 4;
    localparam int          LK_ANALOG         = 3;
    localparam int          LK_FREQ           = 2;
    localparam int          LK_PHASE          = 1;
    localparam int          LK_ALL            = 0;
    // Loop state fields.
    localparam int          LS_REF_HI         = 4;
    localparam int          LS_REF_LO         = 3;
    localparam int          LS_SWITCH         = 2;
    localparam int          LS_HOLDOVER       = 1;
    localparam int          LS_FREERUN        = 0;
    // Limit status fields.
    localparam int          LM_DEMAP          = 3;
    localparam int          LM_SLEW           = 2;
    localparam int          LM_FCLAMP         = 1;
    localparam int          LM_HIST           = 0;
    localparam int          HIST_W            = 30;
    localparam int          IRQ_W             = 4;
    // Interrupt status bits.
    localparam int          IRQ_LOCK_CHG      = 0;
    localparam int          IRQ_MODE_CHG      = 1;
    localparam int          IRQ_LIMIT_CHG     = 2;
    localparam int          IRQ_UPDATE_DONE   = 3;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'b10;
    localparam logic [1:0]  HSIZE_WORD        = 2'b10;
endpackage
`default_nettype wire

// ---- verilog/cls_status_bank.sv ----
// Channel 0 loop status register bank with AHB-Lite slave and interrupt.
`default_nettype none
// Functional notes
// - The whole channel 0 status range is read only; writes change nothing.
// - Lock bit 4 holds the analog oscillator calibration state taken at the last update strobe, 1 running.
// - Lock bit 3 shows analog loop lock, 1 locked.
// - Lock bit 2 shows digital loop frequency lock, 1 locked.
// - Lock bit 1 shows digital loop phase lock, 1 locked.
// - Lock bit 0 set only when system, analog and digital loops all locked.
// - Lock status bits 7 to 5 read zero.
// - Loop state bits 4:3 hold current input: 00 A, 01 B, 10 C, 11 D.
// - Loop state bit 2 high while switching input references.
// - Loop state bit 1 high while in holdover.
// - Loop state bit 0 high while in free run.
// - Limit bit 3 high while the demapping controller is clamped.
// - Limit bit 2 high while the phase slew limiter restricts the loop.
// - Limit bit 1 high while output frequency is held at a clamp.
// - Limit bit 0 high once averaged tuning history is available.
// - 30-bit tuning history in four bytes, low byte first, top byte bits 29:24.
module cls_status_bank
    import cls_pkg::*;
(
    // Clock and reset.
    input  wire  logic                ref_clk,
    input  wire  logic                rst_b,
    // AHB-Lite slave.
    input  wire  logic                hsel,
    input  wire  logic [31:0]         haddr,
    input  wire  logic [1:0]          htrans,
    input  wire  logic                hwrite,
    input  wire  logic [2:0]          hsize,
    input  wire  logic [31:0]         hwdata,
    input  wire  logic                hready,
    output       logic [31:0]         hrdata,
    output       logic                hreadyout,
    output       logic                hresp,
    // Live loop status, on the same clock.
    input  wire  logic                system_loop_locked,
    input  wire  logic                oscillator_calibration_running,
    input  wire  logic                analog_loop_zero_locked,
    input  wire  logic                digital_loop_zero_freq_locked,
    input  wire  logic                digital_loop_zero_phase_locked,
    input  wire  logic [1:0]          current_input_select,
    input  wire  logic                digital_loop_zero_switching,
    input  wire  logic                digital_loop_zero_holdover,
    input  wire  logic                digital_loop_zero_freerun,
    input  wire  logic                demap_clamped,
    input  wire  logic                phase_slew_limited,
    input  wire  logic                freq_clamped,
    input  wire  logic                tuning_history_ready,
    input  wire  logic [HIST_W-1:0]   tuning_history,
    // Interrupt.
    output       logic                irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture.

    logic        dp_valid;
    logic        dp_write;
    logic [11:0] dp_index;
    logic        addr_ok;

    assign addr_ok = (htrans == HTRANS_NONSEQ) && hsel && hready;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_index <= 12'h000;
        end else if (hready) begin
            dp_valid <= addr_ok;
            dp_write <= hwrite;
            dp_index <= haddr[ADDR_SHIFT+11:ADDR_SHIFT];
        end
    end

    // Every access finishes in its first data cycle with an OKAY answer.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wr_update;
    logic rd_irq_status;
    logic wr_mask;

    assign wr_update     = dp_valid && dp_write && (dp_index == IDX_UPDATE)
                           && (hwdata[7:0] == UPDATE_STROBE_VAL);
    assign rd_irq_status = dp_valid && !dp_write && (dp_index == IDX_IRQ_STATUS);
    assign wr_mask       = dp_valid && dp_write && (dp_index == IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Live status assembly.

    logic [7:0] live_lock;
    logic [7:0] live_loop;
    logic [7:0] live_limit;

    always_comb begin
        live_lock                 = RESET_BYTE;
        live_lock[LK_CAL]         = oscillator_calibration_running;
        live_lock[LK_ANALOG]      = analog_loop_zero_locked;
        live_lock[LK_FREQ]        = digital_loop_zero_freq_locked;
        live_lock[LK_PHASE]       = digital_loop_zero_phase_locked;
        // The digital loop counts as locked only with both phase and frequency lock.
        live_lock[LK_ALL]         = system_loop_locked && analog_loop_zero_locked
                                    && digital_loop_zero_freq_locked
                                    && digital_loop_zero_phase_locked;
        live_loop                 = RESET_BYTE;
        live_loop[LS_REF_HI:LS_REF_LO] = current_input_select;
        live_loop[LS_SWITCH]      = digital_loop_zero_switching;
        live_loop[LS_HOLDOVER]    = digital_loop_zero_holdover;
        live_loop[LS_FREERUN]     = digital_loop_zero_freerun;
        live_limit                = RESET_BYTE;
        live_limit[LM_DEMAP]      = demap_clamped;
        live_limit[LM_SLEW]       = phase_slew_limited;
        live_limit[LM_FCLAMP]     = freq_clamped;
        live_limit[LM_HIST]       = tuning_history_ready;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Readable copy, refreshed only by the update strobe.

    logic [7:0]        lock_status;
    logic [7:0]        loop_state;
    logic [7:0]        limit_status;
    logic [HIST_W-1:0] history;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_status  <= RESET_BYTE;
            loop_state   <= RESET_BYTE;
            limit_status <= RESET_BYTE;
            history      <= '0;
        end else if (wr_update) begin
            lock_status  <= live_lock;
            loop_state   <= live_loop;
            limit_status <= live_limit;
            history      <= tuning_history;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: events are each capture and the changes seen between successive captures.

    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;

    always_comb begin
        irq_event                  = '0;
        irq_event[IRQ_LOCK_CHG]    = wr_update && (live_lock != lock_status);
        irq_event[IRQ_MODE_CHG]    = wr_update && (live_loop != loop_state);
        irq_event[IRQ_LIMIT_CHG]   = wr_update && (live_limit != limit_status);
        irq_event[IRQ_UPDATE_DONE] = wr_update;
    end

    // A new event in the cycle of the clearing read survives it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
        end else if (rd_irq_status) begin
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= hwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data. Status registers have no write path at all.

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (dp_index)
            IDX_LOCK_STATUS:  next_rdata[7:0] = lock_status;
            IDX_LOOP_STATE:   next_rdata[7:0] = loop_state;
            IDX_LIMIT_STATUS: next_rdata[7:0] = limit_status;
            IDX_HISTORY_B0:   next_rdata[7:0] = history[7:0];
            IDX_HISTORY_B1:   next_rdata[7:0] = history[15:8];
            IDX_HISTORY_B2:   next_rdata[7:0] = history[23:16];
            IDX_HISTORY_B3:   next_rdata[5:0] = history[29:24];
            IDX_IRQ_STATUS:   next_rdata[IRQ_W-1:0] = irq_status;
            IDX_IRQ_MASK:     next_rdata[IRQ_W-1:0] = irq_mask;
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    assign hrdata = (dp_valid && !dp_write) ? next_rdata : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions: the readable copy moves only on an update strobe.

    AST_HOLD_WITHOUT_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wr_update |=> $stable(lock_status) && $stable(loop_state) && $stable(limit_status))
        else $error("status copy changed without update strobe");
    AST_HISTORY_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wr_update |=> $stable(history))
        else $error("history copy changed without update strobe");
    AST_WRITE_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && dp_write && dp_index == IDX_LOOP_STATE |=> $stable(loop_state))
        else $error("write changed a status register");
    // Writes anywhere in the status range must leave every copy untouched.
    AST_WRITE_NO_EFFECT_ALL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && dp_write && dp_index >= IDX_LOCK_STATUS && dp_index <= IDX_HISTORY_B3
        |=> $stable(lock_status) && $stable(loop_state) && $stable(limit_status) && $stable(history))
        else $error("write changed the status range");
    AST_STROBE_VALUE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && dp_write && dp_index == IDX_UPDATE && hwdata[7:0] != UPDATE_STROBE_VAL
        |=> $stable(lock_status) && $stable(history))
        else $error("update register acted on a value other than the strobe");

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions: captured lock status.
    // Each capture check looks one cycle after the strobe, at the copy that the strobe loaded.

    AST_CAL_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> lock_status[LK_CAL] == $past(oscillator_calibration_running))
        else $error("calibration bit wrong");
    AST_ANALOG_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> lock_status[LK_ANALOG] == $past(analog_loop_zero_locked))
        else $error("analog lock bit wrong");
    AST_FREQ_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> lock_status[LK_FREQ] == $past(digital_loop_zero_freq_locked))
        else $error("frequency lock bit wrong");
    AST_PHASE_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> lock_status[LK_PHASE] == $past(digital_loop_zero_phase_locked))
        else $error("phase lock bit wrong");
    AST_ALL_LOCKED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lock_status[LK_ALL] |-> lock_status[LK_ANALOG] && lock_status[LK_FREQ] && lock_status[LK_PHASE])
        else $error("all-locked set with a loop unlocked");
    AST_ALL_LOCKED_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> lock_status[LK_ALL] == ($past(system_loop_locked) && $past(analog_loop_zero_locked)
            && $past(digital_loop_zero_freq_locked) && $past(digital_loop_zero_phase_locked)))
        else $error("all-locked bit wrong");
    AST_LOCK_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lock_status[7:5] == 3'b000)
        else $error("lock reserved bits nonzero");

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions: captured loop state and limit status.

    AST_REF_SEL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> loop_state[LS_REF_HI:LS_REF_LO] == $past(current_input_select))
        else $error("reference field wrong");
    AST_MODES: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> loop_state[2:0] == {$past(digital_loop_zero_switching),
            $past(digital_loop_zero_holdover), $past(digital_loop_zero_freerun)})
        else $error("mode bits wrong");
    AST_SWITCH_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> loop_state[LS_SWITCH] == $past(digital_loop_zero_switching))
        else $error("switching bit wrong");
    AST_HOLDOVER_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> loop_state[LS_HOLDOVER] == $past(digital_loop_zero_holdover))
        else $error("holdover bit wrong");
    AST_FREERUN_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> loop_state[LS_FREERUN] == $past(digital_loop_zero_freerun))
        else $error("free run bit wrong");
    AST_LOOP_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        loop_state[7:5] == 3'b000)
        else $error("loop state reserved bits nonzero");
    AST_LIMITS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> limit_status[3:0] == {$past(demap_clamped), $past(phase_slew_limited),
            $past(freq_clamped), $past(tuning_history_ready)})
        else $error("limit bits wrong");
    AST_SLEW_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> limit_status[LM_SLEW] == $past(phase_slew_limited))
        else $error("slew limit bit wrong");
    AST_FCLAMP_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> limit_status[LM_FCLAMP] == $past(freq_clamped))
        else $error("frequency clamp bit wrong");
    AST_HIST_READY_BIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> limit_status[LM_HIST] == $past(tuning_history_ready))
        else $error("history available bit wrong");
    AST_LIMIT_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        limit_status[7:4] == 4'h0)
        else $error("limit reserved bits nonzero");

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions: read path. A read shows the copy of the last strobe, never the live inputs.

    AST_READ_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_LOCK_STATUS |-> hrdata == {24'h00_0000, lock_status})
        else $error("lock status read wrong");
    AST_READ_LOOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_LOOP_STATE |-> hrdata == {24'h00_0000, loop_state})
        else $error("loop state read wrong");
    AST_READ_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_LIMIT_STATUS |-> hrdata == {24'h00_0000, limit_status})
        else $error("limit status read wrong");
    AST_HISTORY_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> history == $past(tuning_history))
        else $error("history copy differs from live word");
    AST_HIST_B0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_HISTORY_B0 |-> hrdata == {24'h00_0000, history[7:0]})
        else $error("history byte 0 wrong");
    AST_HIST_B1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_HISTORY_B1 |-> hrdata == {24'h00_0000, history[15:8]})
        else $error("history byte 1 wrong");
    AST_HIST_B2: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_HISTORY_B2 |-> hrdata == {24'h00_0000, history[23:16]})
        else $error("history byte 2 wrong");
    AST_HIST_TOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_HISTORY_B3 |-> hrdata == {26'h000_0000, history[29:24]})
        else $error("history top byte wrong");

    AST_READ_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_IRQ_STATUS |-> hrdata == {28'h000_0000, irq_status})
        else $error("interrupt status read wrong");
    AST_READ_MASK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index == IDX_IRQ_MASK |-> hrdata == {28'h000_0000, irq_mask})
        else $error("interrupt mask read wrong");
    AST_READ_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && !dp_write && dp_index < IDX_LOCK_STATUS |-> hrdata == 32'h0000_0000)
        else $error("read below the status range not zero");
    AST_IDLE_RDATA: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(dp_valid && !dp_write) |-> hrdata == 32'h0000_0000)
        else $error("read data driven outside a read data phase");

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions: interrupt status and mask.
    // A status read never meets a strobe in one cycle, so the clearing read empties the register.

    AST_IRQ_UPDATE_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update |=> irq_status[IRQ_UPDATE_DONE])
        else $error("update done flag not set");
    AST_IRQ_LOCK_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update && (live_lock != lock_status) |=> irq_status[IRQ_LOCK_CHG])
        else $error("lock change flag not set");
    AST_IRQ_MODE_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update && (live_loop != loop_state) |=> irq_status[IRQ_MODE_CHG])
        else $error("loop state change flag not set");
    AST_IRQ_LIMIT_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_update && (live_limit != limit_status) |=> irq_status[IRQ_LIMIT_CHG])
        else $error("limit change flag not set");
    AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !rd_irq_status |=> (irq_status & $past(irq_status)) == $past(irq_status))
        else $error("interrupt flag lost without a read");
    AST_IRQ_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wr_update && !rd_irq_status |=> $stable(irq_status))
        else $error("interrupt status moved without an event");
    AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rd_irq_status |=> irq_status == '0)
        else $error("interrupt status not cleared by its read");

    AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_mask |=> irq_mask == $past(hwdata[IRQ_W-1:0]))
        else $error("interrupt mask not written");
    AST_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wr_mask |=> $stable(irq_mask))
        else $error("interrupt mask moved without a write");

    ////////////////////////////////////////////////////////////////////////////////
    // Cover points for the main scenarios.

    COV_UPDATE:  cover property (@(posedge ref_clk) disable iff (!rst_b) wr_update ##1 rd_irq_status);
    COV_LOCKED:  cover property (@(posedge ref_clk) disable iff (!rst_b) lock_status[LK_ALL]);
    COV_IRQ:     cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq));
    COV_HOLD:    cover property (@(posedge ref_clk) disable iff (!rst_b) wr_update && digital_loop_zero_holdover);
    COV_RO_WR:   cover property (@(posedge ref_clk) disable iff (!rst_b)
        dp_valid && dp_write && dp_index == IDX_LOCK_STATUS);

endmodule
`default_nettype wire

// ---- verif/tb_cls_status_bank.sv ----
// Self-checking testbench for the channel 0 loop status bank.
`default_nettype none
module tb_cls_status_bank
    import cls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int     LIMIT = 6000;
    logic              ref_clk = 1'b0;
    logic              rst_b, hsel, hwrite, hreadyout, hresp, irq, irq_seen;
    logic [31:0]       haddr, hwdata, hrdata, v, a, b;
    logic [1:0]        htrans, sel;
    logic [2:0]        hsize;
    logic              sys_lk, cal, an_lk, fr_lk, ph_lk, sw, ho, fr_run, dm, sl, fc, hr;
    logic [HIST_W-1:0] hist;
    logic [7:0]        exp_b [7];
    logic [3:0]        irq_st, mask;
    logic [31:0]       rng = 32'h0000_C343;
    int                errors, cmp_count, cycles;
    wire logic         hready = hreadyout;

    cls_status_bank dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .system_loop_locked(sys_lk), .oscillator_calibration_running(cal),
        .analog_loop_zero_locked(an_lk), .digital_loop_zero_freq_locked(fr_lk),
        .digital_loop_zero_phase_locked(ph_lk), .current_input_select(sel),
        .digital_loop_zero_switching(sw), .digital_loop_zero_holdover(ho), .digital_loop_zero_freerun(fr_run),
        .demap_clamped(dm), .phase_slew_limited(sl), .freq_clamped(fc), .tuning_history_ready(hr),
        .tuning_history(hist), .irq(irq)
    );

    always #12.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // Samples at the falling edge so the values match what the next rising edge takes.
    task automatic wait_rdy(output logic [31:0] rd);
        logic rdy;
        rdy = 1'b0;
        while (rdy !== 1'b1) begin
            @(negedge ref_clk);
            rdy = hreadyout;
            rd = hrdata;
            irq_seen = irq;
            @(posedge ref_clk);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {18'h0_0000, idx, 2'b00};
        hwrite <= wr;
        hsize <= {1'b0, HSIZE_WORD};
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic set_live(input logic [31:0] x, input logic [31:0] y);
        {sys_lk, cal, an_lk, fr_lk, ph_lk, sel, sw, ho, fr_run, dm, sl, fc, hr} <= x[13:0];
        hist <= y[HIST_W-1:0];
    endtask

    // Reference model of one capture: new copies plus the change and completion events.
    task automatic model_capture();
        logic [7:0] nb [3];
        nb[0] = {3'b000, cal, an_lk, fr_lk, ph_lk, sys_lk & an_lk & fr_lk & ph_lk};
        nb[1] = {3'b000, sel, sw, ho, fr_run};
        nb[2] = {4'h0, dm, sl, fc, hr};
        for (int k = 0; k < 3; k++) begin
            if (nb[k] != exp_b[k]) irq_st[k] = 1'b1;
            exp_b[k] = nb[k];
        end
        irq_st[IRQ_UPDATE_DONE] = 1'b1;
        exp_b[3] = hist[7:0];
        exp_b[4] = hist[15:8];
        exp_b[5] = hist[23:16];
        exp_b[6] = {2'b00, hist[29:24]};
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        {sys_lk, cal, an_lk, fr_lk, ph_lk, sel, sw, ho, fr_run, dm, sl, fc, hr} = 14'h0000;
        hist = '0;
        foreach (exp_b[k]) exp_b[k] = 8'h00;
        irq_st = 4'h0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        for (int k = 0; k < 7; k++) begin
            bus(1'b0, IDX_LOCK_STATUS + 12'(k), 32'h0, v);
            chk(v, 32'h0000_0000);
        end
        chk({31'h0, hresp}, 32'h0000_0000);
        $display("test reset values done");
        for (int i = 0; i < 24; i++) begin
            a = xs();
            b = xs();
            if (i % 3 == 0) a = a | 32'h0000_2E00;
            mask = 4'(xs());
            bus(1'b1, IDX_IRQ_MASK, {28'h0, mask}, v);
            chk({31'h0, irq_seen}, 32'h0000_0000);
            set_live(a, b);
            bus(1'b1, IDX_UPDATE, {24'h0, UPDATE_STROBE_VAL}, v);
            model_capture();
            set_live(xs(), xs());
            bus(1'b1, IDX_UPDATE, 32'h0000_0002, v);
            bus(1'b1, IDX_LOCK_STATUS + 12'(i % 7), xs(), v);
            chk({31'h0, irq_seen}, {31'h0, |(irq_st & mask)});
            for (int k = 0; k < 7; k++) begin
                bus(1'b0, IDX_LOCK_STATUS + 12'(k), 32'h0, v);
                chk(v, {24'h0, exp_b[k]});
            end
            bus(1'b0, IDX_IRQ_MASK, 32'h0, v);
            chk(v, {28'h0, mask});
            bus(1'b0, IDX_IRQ_STATUS, 32'h0, v);
            chk(v, {28'h0, irq_st});
            irq_st = 4'h0;
        end
        $display("test random capture and interrupt done");
        bus(1'b0, 12'h0ABC, 32'h0, v);
        chk(v, 32'h0000_0000);
        $display("test unmapped read done");
        give_verdict();
    end
endmodule
`default_nettype wire
